// *** bioimp_drive_config.sv ***
// drive configuration decode for a bioimpedance channel, with ahb-lite slave
// Operation
// - freq codes 0100..1001 divide master clock by 4..128; above divide by 256
// - codes 0000..0011 give about 4x, 2x, 1x, 0.5x master clock
// - frequencies follow master clock: 32768, 32000, 32000, 31968 Hz
// - monitor active only if enabled, channel on and generators on
// - enabled monitor flags compliance violations of the current sources
// - magnitude 000 turns generators off, drive pins float
// - magnitude 001..111 gives 8,16,32,48,64,80,96 microamps
// - freq code 0010 and above: phase is field times 11.25 degrees
// - freq code 0001: phase uses upper three bits, 22.5 degree steps
// - freq code 0000: phase uses upper two bits, 45 degree steps
// - fast rate: lowpass 00 bypass, else master clock over 8192/4096/2048
// - lowpass 11 at slow rate replaced by 4 Hz default
// - substituted lowpass: register keeps written value, read shows effective
// - sample rate is master clock over 512, halved when rate bit set
//
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`include "drive_cfg_map.svh"

module bioimp_drive_config
  import drive_cfg_pkg::*;
#(
  parameter int DEBOUNCE_CYC = `MON_DEBOUNCE_CYC
)
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [7:0]  haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // analogue status and compliance comparators
  input  wire logic        channel_active_i,
  input  wire logic        comp_pos_viol_i,
  input  wire logic        comp_neg_viol_i,
  // decoded drive controls
  output logic             gen_enable_o,
  output logic             drive_pos_pin_oe_o,
  output logic             drive_neg_pin_oe_o,
  output logic      [6:0]  drive_current_ua_o,
  output logic      [3:0]  freq_div_log2_o,
  output logic      [1:0]  freq_mult_code_o,
  output logic      [15:0] phase_cdeg_o,
  output logic      [1:0]  lpf_effective_o,
  output logic      [13:0] lpf_div_o,
  output logic      [10:0] rate_div_o,
  output logic      [16:0] master_hz_o,
  output logic             monitor_active_o,
  // interrupt
  output logic             irq_o
);

  initial
  begin
    if (DEBOUNCE_CYC < 1 || DEBOUNCE_CYC > 255)
      $error("DEBOUNCE_CYC out of range");
  end

  logic [23:0] imp_cfg_q;
  logic [1:0]  master_clock_sel_q;
  logic [1:0]  irq_status_q;
  logic [1:0]  irq_mask_q;
  logic [7:0]  haddr_q;
  bus_state_e  bus_q;
  logic [7:0]  deb_cnt_q;
  logic        viol_q;

  // register fields
  logic       impedance_rate_sel;
  logic [1:0] impedance_lowpass_sel;
  freq_code_t drive_mod_freq_sel;
  logic       drive_monitor_en;
  logic [2:0] drive_magnitude_sel;
  logic [3:0] drive_phase_offset;
  assign impedance_rate_sel    = imp_cfg_q[`FLD_RATE];
  assign impedance_lowpass_sel = imp_cfg_q[`FLD_LPF_HI:`FLD_LPF_LO];
  assign drive_mod_freq_sel    = imp_cfg_q[`FLD_FREQ_HI:`FLD_FREQ_LO];
  assign drive_monitor_en      = imp_cfg_q[`FLD_MON_EN];
  assign drive_magnitude_sel   = imp_cfg_q[`FLD_MAG_HI:`FLD_MAG_LO];
  assign drive_phase_offset    = imp_cfg_q[`FLD_PH_HI:`FLD_PH_LO];
  // ahb: address phase accepted when selected, nonseq/seq and bus ready
  logic accept;
  assign accept = hsel_i && htrans_i[1] && hready_i;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bus_q   <= BUS_IDLE;
      haddr_q <= 8'h00;
    end
    else if (accept)
    begin
      bus_q   <= hwrite_i ? BUS_WRITE : BUS_READ;
      haddr_q <= haddr_i;
    end
    else if (hready_i)
      bus_q <= BUS_IDLE;
  end

  // zero wait state slave, always okay
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  // write strobes live only in the data phase of an accepted write
  logic wr_cfg;
  logic wr_gen;
  logic wr_stat;
  logic wr_mask;
  assign wr_cfg  = (bus_q == BUS_WRITE) && (haddr_q == `OFS_IMP_CFG);
  assign wr_gen  = (bus_q == BUS_WRITE) && (haddr_q == `OFS_GEN_CFG);
  assign wr_stat = (bus_q == BUS_WRITE) && (haddr_q == `OFS_IRQ_STATUS);
  assign wr_mask = (bus_q == BUS_WRITE) && (haddr_q == `OFS_IRQ_MASK);
  // configuration storage keeps written value, including unsupported lowpass
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      imp_cfg_q <= `RST_IMP_CFG;
    else if (wr_cfg)
      imp_cfg_q <= hwdata_i[23:0];
  end
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      master_clock_sel_q <= 2'(`RST_GEN_CFG);
    else if (wr_gen)
      master_clock_sel_q <= hwdata_i[1:0];
  end
  // master clock rate per selection
  always_comb
  begin
    case (master_clock_sel_q)
      2'h0:    master_hz_o = 17'(`MASTER_CLOCK_SEL_HZ_0);
      2'h3:    master_hz_o = 17'(`MASTER_CLOCK_SEL_HZ_3);
      default: master_hz_o = 17'(`MASTER_CLOCK_SEL_HZ_1);
    endcase
  end
  // sample rate divisor, slow rate halves the rate
  assign rate_div_o = impedance_rate_sel ? 11'(2 * `RATE_DIV_FAST)
                                         : 11'(`RATE_DIV_FAST);
  // lowpass substitution; 11 only valid at the fast rate
  always_comb
  begin
    lpf_effective_o = impedance_lowpass_sel;
    if (impedance_rate_sel && impedance_lowpass_sel == 2'h3)
      lpf_effective_o = `LPF_DEFAULT;
    case (lpf_effective_o)
      2'h1:    lpf_div_o = 14'h2000;
      2'h2:    lpf_div_o = 14'h1000;
      2'h3:    lpf_div_o = 14'h0800;
      default: lpf_div_o = 14'h0000; // bypass
    endcase
  end
  // frequency: multiplier for low codes, power-of-two divider for the rest
  always_comb
  begin
    freq_mult_code_o = 2'h0;
    freq_div_log2_o  = 4'h0;
    if (drive_mod_freq_sel < 4'h4)
      freq_mult_code_o = drive_mod_freq_sel[1:0];
    else if (drive_mod_freq_sel <= 4'h9)
      freq_div_log2_o = drive_mod_freq_sel - 4'h2;
    else
      freq_div_log2_o = 4'h8;
  end
  // phase offset resolution depends on the frequency code
  always_comb
  begin
    case (drive_mod_freq_sel)
      4'h0:    phase_cdeg_o = 16'({drive_phase_offset[3:2], 2'b00})
                              * `PH_STEP_FINE;
      4'h1:    phase_cdeg_o = 16'({drive_phase_offset[3:1], 1'b0})
                              * `PH_STEP_FINE;
      default: phase_cdeg_o = 16'(drive_phase_offset)
                              * `PH_STEP_FINE;
    endcase
  end
  // magnitude decode; 000 floats the pins
  always_comb
  begin
    case (drive_magnitude_sel)
      3'h1:    drive_current_ua_o = 7'd8;
      3'h2:    drive_current_ua_o = 7'd16;
      3'h3:    drive_current_ua_o = 7'd32;
      3'h4:    drive_current_ua_o = 7'd48;
      3'h5:    drive_current_ua_o = 7'd64;
      3'h6:    drive_current_ua_o = 7'd80;
      3'h7:    drive_current_ua_o = 7'd96;
      default: drive_current_ua_o = 7'd0;
    endcase
  end
  assign gen_enable_o       = (drive_magnitude_sel != 3'h0);
  assign drive_pos_pin_oe_o = gen_enable_o;
  assign drive_neg_pin_oe_o = gen_enable_o;
  // monitor only meaningful with channel and generators running
  assign monitor_active_o = drive_monitor_en && channel_active_i
                            && gen_enable_o;
  // debounce so a single glitch on a comparator does not raise the event
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      deb_cnt_q <= 8'h00;
      viol_q    <= 1'b0;
    end
    else if (monitor_active_o && (comp_pos_viol_i || comp_neg_viol_i))
    begin
      if (deb_cnt_q < 8'(DEBOUNCE_CYC))
        deb_cnt_q <= deb_cnt_q + 8'h01;
      viol_q <= (deb_cnt_q >= 8'(DEBOUNCE_CYC - 1));
    end
    else
    begin
      deb_cnt_q <= 8'h00;
      viol_q    <= 1'b0;
    end
  end

  // sticky status: bit0 compliance event, bit1 config write; set beats clear
  logic [1:0] evt;
  assign evt = {wr_cfg, viol_q};
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      irq_status_q <= 2'h0;
    else
      irq_status_q <= (irq_status_q & ~(wr_stat ? hwdata_i[1:0] : 2'h0))
                      | evt;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      irq_mask_q <= 2'h0;
    else if (wr_mask)
      irq_mask_q <= hwdata_i[1:0];
  end

  assign irq_o = |(irq_status_q & irq_mask_q);

  // read mux, reads of the config show the effective lowpass
  always_comb
  begin
    hrdata_o = 32'h0;
    if (bus_q == BUS_READ)
    begin
      case (haddr_q)
        `OFS_IMP_CFG:
          hrdata_o = {8'h00, imp_cfg_q[23:14], lpf_effective_o,
                      imp_cfg_q[11:0]};
        `OFS_GEN_CFG:     hrdata_o = {30'h0, master_clock_sel_q};
        `OFS_IRQ_STATUS:  hrdata_o = {30'h0, irq_status_q};
        `OFS_IRQ_MASK:    hrdata_o = {30'h0, irq_mask_q};
        `OFS_DRIVE_STAT:  hrdata_o = {29'h0, viol_q, monitor_active_o,
                                      gen_enable_o};
        `OFS_DRIVE_PARAM: hrdata_o = {phase_cdeg_o, 1'b0,
                                      drive_current_ua_o, freq_div_log2_o,
                                      2'b00, freq_mult_code_o};
        default:          hrdata_o = 32'h0;
      endcase
    end
  end

  // checks
  lpf_subst_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (impedance_rate_sel && impedance_lowpass_sel == 2'h3)
      |-> lpf_effective_o == 2'h1 && lpf_div_o == 14'h2000)
    else $error("lowpass not substituted");
  lpf_fast_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!impedance_rate_sel && impedance_lowpass_sel == 2'h3)
      |-> lpf_div_o == 14'h0800)
    else $error("fast lowpass wrong");
  cfg_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_cfg |=> imp_cfg_q == $past(hwdata_i[23:0]))
    else $error("config write lost");
  mag_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    drive_magnitude_sel == 3'h0
      |-> !drive_pos_pin_oe_o && !drive_neg_pin_oe_o
          && drive_current_ua_o == 7'd0)
    else $error("pins driven while off");
  mag_max_a: assert property (@(posedge clk_i) disable iff (rst_i)
    drive_magnitude_sel == 3'h7 |-> drive_current_ua_o == 7'd96)
    else $error("top magnitude wrong");
  freq_div_a: assert property (@(posedge clk_i) disable iff (rst_i)
    drive_mod_freq_sel >= 4'ha |-> freq_div_log2_o == 4'h8)
    else $error("top divider wrong");
  freq_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    drive_mod_freq_sel == 4'h4 |-> freq_div_log2_o == 4'h2)
    else $error("divide by four wrong");
  freq_mult_a: assert property (@(posedge clk_i) disable iff (rst_i)
    drive_mod_freq_sel == 4'h3 |-> freq_mult_code_o == 2'h3
                                   && freq_div_log2_o == 4'h0)
    else $error("multiplier code wrong");
  phase_coarse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    drive_mod_freq_sel == 4'h0 && drive_phase_offset == 4'hf
      |-> phase_cdeg_o == 16'd13500)
    else $error("coarse phase wrong");
  phase_mid_a: assert property (@(posedge clk_i) disable iff (rst_i)
    drive_mod_freq_sel == 4'h1 && drive_phase_offset == 4'hf
      |-> phase_cdeg_o == 16'd15750)
    else $error("mid phase wrong");
  phase_fine_a: assert property (@(posedge clk_i) disable iff (rst_i)
    drive_mod_freq_sel == 4'h2 && drive_phase_offset == 4'hf
      |-> phase_cdeg_o == 16'd16875)
    else $error("fine phase wrong");
  mon_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !monitor_active_o |=> !viol_q)
    else $error("violation while inactive");
  viol_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    viol_q && irq_mask_q[0] && !wr_mask |=> irq_o)
    else $error("violation missed irq");
  master_a: assert property (@(posedge clk_i) disable iff (rst_i)
    master_clock_sel_q == 2'h3 |-> master_hz_o == 17'd31968)
    else $error("master rate wrong");
  rate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    impedance_rate_sel |-> rate_div_o == 11'd1024)
    else $error("slow rate wrong");

  viol_c: cover property (@(posedge clk_i) disable iff (rst_i)
    monitor_active_o ##1 viol_q);
  subst_c: cover property (@(posedge clk_i) disable iff (rst_i)
    bus_q == BUS_READ && haddr_q == `OFS_IMP_CFG && lpf_effective_o
      != impedance_lowpass_sel);
  irq_c: cover property (@(posedge clk_i) disable iff (rst_i)
    !irq_o ##1 irq_o);

endmodule : bioimp_drive_config

// *** drive_cfg_map.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef DRIVE_CFG_MAP_SVH
`define DRIVE_CFG_MAP_SVH

// byte offsets on the register bus
`define OFS_IMP_CFG      8'h00
`define OFS_GEN_CFG      8'h04
`define OFS_IRQ_STATUS   8'h08
`define OFS_IRQ_MASK     8'h0c
`define OFS_DRIVE_STAT   8'h10
`define OFS_DRIVE_PARAM  8'h14

// impedance channel configuration fields
`define FLD_RATE         23
`define FLD_LPF_HI       13
`define FLD_LPF_LO       12
`define FLD_FREQ_HI      11
`define FLD_FREQ_LO      8
`define FLD_MON_EN       7
`define FLD_MAG_HI       6
`define FLD_MAG_LO       4
`define FLD_PH_HI        3
`define FLD_PH_LO        0

// reset values
`define RST_IMP_CFG      24'h201800
`define RST_GEN_CFG      8'h00

// low-pass default for unsupported combinations
`define LPF_DEFAULT      2'h1

// phase step sizes in hundredths of a degree
`define PH_STEP_FINE     16'd1125

// master clock rates in Hz
`define MASTER_CLOCK_SEL_HZ_0       32768
`define MASTER_CLOCK_SEL_HZ_1       32000
`define MASTER_CLOCK_SEL_HZ_3       31968

// sample rate divisor of the master clock
`define RATE_DIV_FAST    512

// compliance debounce time in ns and cycles at 125 MHz
`define MON_DEBOUNCE_NS  64
`define CLK_PERIOD_NS    8
`define MON_DEBOUNCE_CYC ((`MON_DEBOUNCE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** drive_cfg_pkg.sv ***
// types shared by the drive configuration block
package drive_cfg_pkg;

  // bus data phase state, one-hot
  typedef enum logic [2:0]
  {
    BUS_IDLE  = 3'b001,
    BUS_WRITE = 3'b010,
    BUS_READ  = 3'b100
  } bus_state_e;

  typedef logic [3:0] freq_code_t;

endpackage : drive_cfg_pkg

// *** electrode_model.sv ***
// body electrode model: compliance comparators behind the drive pins
`timescale 1ns/100ps

module electrode_model
(
  // drive pin enables from the block
  input  wire logic pos_oe_i,
  input  wire logic neg_oe_i,
  // lead-off requests from the bench
  input  wire logic pos_off_i,
  input  wire logic neg_off_i,
  // comparator outputs
  output logic      pos_viol_o,
  output logic      neg_viol_o
);
  // an open lead only reaches compliance while its source drives it
  assign pos_viol_o = pos_oe_i & pos_off_i;
  assign neg_viol_o = neg_oe_i & neg_off_i;
endmodule : electrode_model

// *** tb.sv ***
// self-checking bench for the drive configuration block
`timescale 1ns/100ps
`include "drive_cfg_map.svh"

module tb;
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        hsel_i   = 1'b0;
  logic [7:0]  haddr_i  = 8'h00;
  logic [1:0]  htrans_i = 2'h0;
  logic        hwrite_i = 1'b0;
  logic [2:0]  hsize_i  = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  logic        chan_on  = 1'b0;
  logic        off_p    = 1'b0;
  logic        off_n    = 1'b0;
  logic [31:0] rdv;
  logic [3:0]  f, p;
  logic [2:0]  m;
  logic [1:0]  eff;
  int          fails = 0, cmp_count = 0, cycles = 0;
  integer      seed = 32'h666e;
  wire logic [31:0] hrdata;
  wire logic        hready, hresp, vp, vn, gen, oe_p, oe_n, mon, irq;
  wire logic [6:0]  ua;
  wire logic [3:0]  dlog;
  wire logic [1:0]  mult, lpf;
  wire logic [15:0] ph;
  wire logic [13:0] ldiv;
  wire logic [10:0] rdiv;
  wire logic [16:0] mhz;

  // short debounce keeps the compliance path quick to reach
  bioimp_drive_config #(.DEBOUNCE_CYC(1)) bioimp_drive_config_inst
  (
    .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hwdata_i(hwdata_i), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .channel_active_i(chan_on),
    .comp_pos_viol_i(vp), .comp_neg_viol_i(vn), .gen_enable_o(gen),
    .drive_pos_pin_oe_o(oe_p), .drive_neg_pin_oe_o(oe_n),
    .drive_current_ua_o(ua), .freq_div_log2_o(dlog),
    .freq_mult_code_o(mult), .phase_cdeg_o(ph), .lpf_effective_o(lpf),
    .lpf_div_o(ldiv), .rate_div_o(rdiv), .master_hz_o(mhz),
    .monitor_active_o(mon), .irq_o(irq)
  );

  electrode_model electrode_model_inst
  (
    .pos_oe_i(oe_p), .neg_oe_i(oe_n), .pos_off_i(off_p),
    .neg_off_i(off_n), .pos_viol_o(vp), .neg_viol_o(vn)
  );

  // free-running clock
  always #4 clk_i = ~clk_i;

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  // hang guard, far above the roughly 470 cycles the tests need
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      end_of_test();
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one single word transfer; waits on hready in both phases
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk_i);
    hsel_i   <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i  <= a;
    hwrite_i <= wr;
    do @(posedge clk_i); while (hready !== 1'b1);
    hsel_i   <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hready !== 1'b1);
    rdv = hrdata;
    #1;
  endtask : xfer

  function automatic logic [3:0] exp_div(input logic [3:0] c);
    return (c < 4'h4) ? 4'h0 : (c > 4'h9) ? 4'h8 : c - 4'h2;
  endfunction : exp_div

  function automatic logic [15:0] exp_ph(input logic [3:0] c,
                                          input logic [3:0] q);
    if (c == 4'h0)
      return 16'(q[3:2]) * 16'd4500;
    if (c == 4'h1)
      return 16'(q[3:1]) * 16'd2250;
    return 16'(q) * 16'd1125;
  endfunction : exp_ph

  function automatic logic [6:0] exp_ua(input logic [2:0] g);
    return (g == 3'h0) ? 7'd0 : (g == 3'h1) ? 7'd8 : 7'(16 * (g - 1));
  endfunction : exp_ua

  // largest magnitude software may pick at a given frequency code
  function automatic int lim(input logic [3:0] c);
    return (c < 4) ? 7 : (c == 4) ? 6 : (c == 5) ? 3 : (c == 6) ? 2 : 1;
  endfunction : lim

  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    xfer(1'b0, `OFS_IMP_CFG, 32'h0);
    check("cfg reset", rdv, 32'h00201800);
    check("bus resp", 32'({hready, hresp}), 32'h2);
    check("pins idle", 32'({gen, oe_p, oe_n}), 32'h0);
    check("master hz", 32'(mhz), 32'd32768);
    check("rate div", 32'(rdiv), 32'd512);
    check("lpf div", 32'(ldiv), 32'h2000);
    $display("test reset done");
    // every frequency code, random phase on even codes and 4'hf on odd, legal magnitudes only
    for (int c = 0; c < 16; c++)
    begin
      f = 4'(c);
      m = 3'($unsigned($random(seed)) % (lim(f) + 1));
      p = c[0] ? 4'hf : 4'($random(seed));
      xfer(1'b1, `OFS_IMP_CFG, {8'h00, 12'h201, f, 1'b0, m, p});
      check("div", 32'(dlog), 32'(exp_div(f)));
      check("mult", 32'(mult), (f < 4) ? 32'(f) : 32'h0);
      check("phase", 32'(ph), 32'(exp_ph(f, p)));
      check("ua", 32'(ua), 32'(exp_ua(m)));
      check("pins", 32'({gen, oe_p, oe_n}), {29'h0, {3{m != 0}}});
      xfer(1'b0, `OFS_DRIVE_PARAM, 32'h0);
      check("param", rdv, {exp_ph(f, p), 1'b0, exp_ua(m), exp_div(f),
                           2'h0, (f < 4) ? f[1:0] : 2'h0});
    end
    $display("test frequency done");
    // master clock, rate and low-pass combinations
    for (int s = 0; s < 32; s++)
    begin
      eff = (s[2] && s[4:3] == 2'h3) ? 2'h1 : s[4:3];
      xfer(1'b1, `OFS_GEN_CFG, 32'(s[1:0]));
      xfer(1'b1, `OFS_IMP_CFG, {8'h00, s[2], 9'h080, s[4:3], 12'h800});
      check("hz", 32'(mhz), (s[1:0] == 0) ? 32'd32768 :
            (s[1:0] == 3) ? 32'd31968 : 32'd32000);
      check("rate", 32'(rdiv), s[2] ? 32'd1024 : 32'd512);
      check("lpf", 32'(lpf), 32'(eff));
      check("ldiv", 32'(ldiv), (eff == 0) ? 0 : 32'h4000 >> eff);
      xfer(1'b0, `OFS_IMP_CFG, 32'h0);
      check("lpf read", 32'(rdv[13:12]), 32'(eff));
    end
    $display("test lowpass done");
    // monitor needs enable, channel and generators together
    for (int k = 0; k < 8; k++)
    begin
      @(posedge clk_i);
      chan_on <= k[0];
      xfer(1'b1, `OFS_IMP_CFG,
           {8'h00, 12'h201, 4'h2, k[2], k[1] ? 3'h2 : 3'h0, 4'h0});
      check("mon", 32'(mon), 32'(k == 7));
    end
    xfer(1'b0, `OFS_IRQ_STATUS, 32'h0);
    check("cfg event", rdv, 32'h2);
    xfer(1'b1, `OFS_IRQ_MASK, 32'h1);
    xfer(1'b1, `OFS_IRQ_STATUS, 32'h3);
    check("irq idle", 32'(irq), 32'h0);
    @(posedge clk_i);
    if ($random(seed) & 1)
      off_p <= 1'b1;
    else
      off_n <= 1'b1;
    for (int w = 0; w < 20 && irq !== 1'b1; w++)
      @(posedge clk_i);
    #1;
    check("irq set", 32'(irq), 32'h1);
    xfer(1'b0, `OFS_IRQ_STATUS, 32'h0);
    check("status", rdv, 32'h1);
    xfer(1'b0, `OFS_DRIVE_STAT, 32'h0);
    check("drive stat", rdv, 32'h7);
    @(posedge clk_i);
    off_p <= 1'b0;
    off_n <= 1'b0;
    xfer(1'b1, `OFS_IRQ_MASK, 32'h0);
    check("irq masked", 32'(irq), 32'h0);
    xfer(1'b1, `OFS_IRQ_STATUS, 32'h1);
    xfer(1'b0, `OFS_IRQ_STATUS, 32'h0);
    check("status clr", rdv, 32'h0);
    $display("test monitor done");
    // unmapped place reads zero and ignores writes
    xfer(1'b1, 8'h1c, $random(seed));
    xfer(1'b0, 8'h1c, 32'h0);
    check("unmapped", rdv, 32'h0);
    $display("test unmapped done");
    end_of_test();
  end
endmodule : tb
